// file: common/rbd_pkg.sv
package rbd_pkg;
	localparam int RBD_SLOTS = 16;
	localparam int RBD_REPORT_BYTES = 15;
	localparam int RBD_TYPE_W = 8;
	// diagnostic report constants
	localparam logic [7:0] RBD_EXT_DEV_HDR = 8'h06;
	localparam logic [7:0] RBD_EXT_ID_HDR = 8'h43;
	localparam logic [7:0] RBD_NO_MASTER_ADDR = 8'hFF;
	// arbitrary neutral identity value, not a real maker code
	localparam logic [15:0] RBD_IDENT_DEFAULT = 16'h5A3C;
	// byte 1 bit positions
	localparam int RBD_S1_OTHER_MASTER = 7;
	localparam int RBD_S1_PRM_ERR = 6;
	localparam int RBD_S1_INVALID = 5;
	localparam int RBD_S1_UNSUPPORTED = 4;
	localparam int RBD_S1_EXT_PRESENT = 3;
	localparam int RBD_S1_CFG_ERR = 2;
	localparam int RBD_S1_NOT_READY = 1;
	localparam int RBD_S1_NO_RESP = 0;
	// byte 2, byte 3 and byte 8 bit positions
	localparam int RBD_S2_INACTIVE = 7;
	localparam int RBD_S2_SYNC = 5;
	localparam int RBD_S2_FREEZE = 4;
	localparam int RBD_S2_ONE = 2;
	localparam int RBD_S2_ZERO = 1;
	localparam int RBD_S2_WAIT_PRM = 0;
	localparam int RBD_S3_ZERO = 7;
	localparam int RBD_B8_REMOTE_REQ = 0;
	// register byte offsets and register bit positions
	localparam logic [7:0] RBD_OFF_CTRL = 8'h00;
	localparam logic [7:0] RBD_OFF_STATUS = 8'h04;
	localparam logic [7:0] RBD_OFF_SLOTS = 8'h08;
	localparam logic [7:0] RBD_OFF_REPORT0 = 8'h0C;
	localparam logic [7:0] RBD_OFF_REPORT3 = 8'h18;
	localparam int RBD_CTRL_LENIENT = 0;
	localparam int RBD_CTRL_SNAP = 1;
	localparam logic RBD_CTRL_LENIENT_RST = 1'b0;
	localparam int RBD_ST_POINT = 4;
	localparam int RBD_ST_OFFLINE = 5;
	localparam int RBD_ST_OUT_HOLD = 6;
	localparam int RBD_ST_OUT_OFF = 7;
	localparam int RBD_ST_IN_OFF = 8;
	localparam int RBD_ST_JUMPER = 9;
	typedef enum logic [2:0] {RBD_DISP_0, RBD_DISP_2, RBD_DISP_3, RBD_DISP_LA, RBD_DISP_UA, RBD_DISP_E} rbd_disp_t;
endpackage

// file: common/rbd_slot_if.sv
`timescale 1ns/1ps
interface rbd_slot_if #(parameter int N = 16);
	logic [N-1:0] removed;
	logic [N-1:0] added;
	logic [N-1:0] wrong;
	logic [N-1:0] mismatch;
	logic [N-1:0] fault;
	modport cmp (output removed, output added, output wrong, output mismatch, output fault);
	modport use_side (input removed, input added, input wrong, input mismatch, input fault);
endinterface

// file: verilog/rbd_slot_cmp.sv
`timescale 1ns/1ps
module rbd_slot_cmp #(
	parameter int N = rbd_pkg::RBD_SLOTS,
	parameter int TW = rbd_pkg::RBD_TYPE_W
) (
	input wire logic [N-1:0] cfg_present,
	input wire logic [N*TW-1:0] cfg_type,
	input wire logic [N-1:0] inst_present,
	input wire logic [N*TW-1:0] inst_type,
	input wire logic [N-1:0] inst_failed,
	rbd_slot_if.cmp slots
);
	import rbd_pkg::*;
	initial begin
		if (N < 1 || TW < 1) begin
			$error("rbd_slot_cmp: bad slot count or type width");
		end
	end
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_slot
			logic differ;
			assign differ = cfg_type[g*TW +: TW] != inst_type[g*TW +: TW];
			assign slots.removed[g] = cfg_present[g] & ~inst_present[g];
			assign slots.added[g] = ~cfg_present[g] & inst_present[g];
			assign slots.wrong[g] = cfg_present[g] & inst_present[g] & differ;
			// a configured slot left empty also counts as a mismatched type
			assign slots.mismatch[g] = slots.removed[g] | slots.wrong[g];
			assign slots.fault[g] = slots.mismatch[g] | (cfg_present[g] & inst_failed[g]);
		end
	endgenerate
endmodule

// file: verilog/rbd_report.sv
`timescale 1ns/1ps
module rbd_report (
	input wire logic [7:0] s1,
	input wire logic [7:0] s2,
	input wire logic prm_done,
	input wire logic [7:0] master_addr,
	input wire logic [15:0] ident,
	input wire logic remote_req,
	rbd_slot_if.use_side slots,
	output logic [rbd_pkg::RBD_REPORT_BYTES*8-1:0] report
);
	import rbd_pkg::*;
	logic [7:0] b [1:RBD_REPORT_BYTES];
	// byte k sits above byte k+1 so byte 1 leads; bit 7 of each byte is its msb
	function automatic int rbd_lsb(input int k);
		return (RBD_REPORT_BYTES - k) * 8;
	endfunction
	always_comb begin
		b[1] = s1;
		b[2] = s2;
		b[3] = 8'h00;
		b[4] = prm_done ? master_addr : RBD_NO_MASTER_ADDR;
		b[5] = ident[15:8];
		b[6] = ident[7:0];
		b[7] = RBD_EXT_DEV_HDR;
		b[8] = 8'h00;
		b[8][RBD_B8_REMOTE_REQ] = remote_req;
		b[9] = 8'h00;
		b[10] = 8'h00;
		b[11] = slots.mismatch[7:0];
		b[12] = slots.mismatch[15:8];
		b[13] = RBD_EXT_ID_HDR;
		b[14] = slots.fault[7:0];
		b[15] = slots.fault[15:8];
	end
	genvar k;
	generate
		for (k = 1; k <= RBD_REPORT_BYTES; k++) begin : g_pack
			assign report[rbd_lsb(k) +: 8] = b[k];
		end
	endgenerate
endmodule

// file: verilog/rbd_diag.sv
`timescale 1ns/1ps
// What this block does
// - diagnostic request returns fifteen byte report
// - bit 7 is msb in every byte
// - first byte carries the station flags
// - invalid response flag always zero
// - second byte: sync, freeze, waiting parameterization
// - configured-but-inactive flag only ever zero
// - second byte bit2 one, bit1 zero
// - third byte all zero
// - byte four master address, else 255
// - bytes five-six identity, high byte first
// - byte seven header constant 0x06
// - byte eight bit0 remote port pending
// - bytes 11-12 slot mismatch bitmap
// - byte thirteen header constant 0x43
// - bytes 14-15 failed or mismatched bitmap
// - strict, removed module: offline, code 2
// - strict, added module ignored, code 0
// - strict, wrong type: offline, code a
// - lenient: 2. or 0., bad slots skipped
// - bus stopped: code 3, inputs off
// - internal failure shows A or E only
// - strict is default, mismatch blocks I/O
// - outputs off or hold per jumper
module rbd_diag #(
	parameter int TW = rbd_pkg::RBD_TYPE_W,
	parameter logic [15:0] IDENT = rbd_pkg::RBD_IDENT_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [rbd_pkg::RBD_SLOTS-1:0] cfg_present,
	input wire logic [rbd_pkg::RBD_SLOTS*TW-1:0] cfg_type,
	input wire logic [rbd_pkg::RBD_SLOTS-1:0] inst_present,
	input wire logic [rbd_pkg::RBD_SLOTS*TW-1:0] inst_type,
	input wire logic [rbd_pkg::RBD_SLOTS-1:0] inst_failed,
	input wire logic prm_other_master,
	input wire logic prm_error,
	input wire logic unsupported_fn,
	input wire logic cfg_error,
	input wire logic not_ready,
	input wire logic no_response,
	input wire logic sync_mode,
	input wire logic freeze_mode,
	input wire logic wait_prm,
	input wire logic prm_done,
	input wire logic [7:0] master_addr,
	input wire logic remote_port_req,
	input wire logic bus_stop,
	input wire logic comm_lost,
	input wire logic diag_fail,
	input wire logic diag_fail_e,
	input wire logic output_off_hold_jumper,
	input wire logic slave_diag_read_instruction,
	output logic diag_valid,
	output logic [rbd_pkg::RBD_REPORT_BYTES*8-1:0] diag_report,
	output rbd_pkg::rbd_disp_t disp_code,
	output logic disp_point,
	output logic base_offline,
	output logic outputs_hold,
	output logic outputs_off,
	output logic inputs_off,
	output logic [rbd_pkg::RBD_SLOTS-1:0] io_update_en
);
	import rbd_pkg::*;
	initial begin
		if (TW < 1 || TW > 32) begin
			$error("rbd_diag: type width out of range");
		end
	end

	rbd_slot_if #(.N(RBD_SLOTS)) slots ();
	rbd_slot_cmp #(.N(RBD_SLOTS), .TW(TW)) u_cmp (
		.cfg_present(cfg_present),
		.cfg_type(cfg_type),
		.inst_present(inst_present),
		.inst_type(inst_type),
		.inst_failed(inst_failed),
		.slots(slots)
	);

	// jumper pin: two-stage synchroniser; a missing jumper reads low, i.e. off
	logic jmp_meta_q, jmp_hold_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			jmp_meta_q <= 1'b0;
			jmp_hold_q <= 1'b0;
		end else begin
			jmp_meta_q <= output_off_hold_jumper;
			jmp_hold_q <= jmp_meta_q;
		end
	end

	// control register and bus slave state
	logic lenient_q;
	logic snap_req_q;
	logic dph_wr_q;
	logic [7:0] dph_addr_q;
	logic aph_take;
	assign aph_take = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dph_wr_q <= 1'b0;
			dph_addr_q <= 8'h00;
		end else begin
			dph_wr_q <= aph_take & hwrite;
			dph_addr_q <= haddr[7:0];
		end
	end

	// strict matching after reset; software opts into lenient
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lenient_q <= RBD_CTRL_LENIENT_RST;
		end else if (dph_wr_q && dph_addr_q == RBD_OFF_CTRL) begin
			lenient_q <= hwdata[RBD_CTRL_LENIENT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			snap_req_q <= 1'b0;
		end else begin
			snap_req_q <= dph_wr_q && dph_addr_q == RBD_OFF_CTRL && hwdata[RBD_CTRL_SNAP];
		end
	end

	// mismatch classification
	logic any_removed, any_wrong, any_added, strict_bad, link_down;
	assign any_removed = |slots.removed;
	assign any_wrong = |slots.wrong;
	assign any_added = |slots.added;
	assign strict_bad = ~lenient_q & (any_removed | any_wrong);
	assign link_down = comm_lost | bus_stop;

	rbd_disp_t disp_d;
	always_comb begin
		if (diag_fail) begin
			disp_d = diag_fail_e ? RBD_DISP_E : RBD_DISP_UA;
		end else if (link_down) begin
			disp_d = RBD_DISP_3;
		end else if (!lenient_q && any_wrong) begin
			disp_d = RBD_DISP_LA;
		end else if (!lenient_q && any_removed) begin
			disp_d = RBD_DISP_2;
		end else if (lenient_q && (any_removed || any_wrong)) begin
			disp_d = RBD_DISP_2;
		end else begin
			// an added module alone changes nothing
			disp_d = RBD_DISP_0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			disp_code <= RBD_DISP_0;
			disp_point <= 1'b0;
		end else begin
			disp_code <= disp_d;
			disp_point <= lenient_q;
		end
	end

	logic offline_d;
	assign offline_d = strict_bad | diag_fail;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			base_offline <= 1'b0;
		end else begin
			base_offline <= offline_d;
		end
	end

	// outputs follow the jumper alone whenever the base stops serving them
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			outputs_hold <= 1'b0;
			outputs_off <= 1'b1;
		end else begin
			outputs_hold <= (offline_d | link_down) & jmp_hold_q;
			outputs_off <= (offline_d | link_down) & ~jmp_hold_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			inputs_off <= 1'b1;
		end else begin
			inputs_off <= link_down | offline_d;
		end
	end

	// lenient mode keeps good slots running; bad and added slots stay idle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			io_update_en <= '0;
		end else if (offline_d || link_down) begin
			io_update_en <= '0;
		end else begin
			io_update_en <= cfg_present & ~slots.mismatch;
		end
	end

	// station status bytes
	logic [7:0] s1, s2;
	always_comb begin
		s1 = 8'h00;
		s1[RBD_S1_OTHER_MASTER] = prm_other_master;
		s1[RBD_S1_PRM_ERR] = prm_error;
		s1[RBD_S1_INVALID] = 1'b0;
		s1[RBD_S1_UNSUPPORTED] = unsupported_fn;
		s1[RBD_S1_EXT_PRESENT] = 1'b1;
		s1[RBD_S1_CFG_ERR] = cfg_error | strict_bad;
		s1[RBD_S1_NOT_READY] = not_ready;
		s1[RBD_S1_NO_RESP] = no_response;
		s2 = 8'h00;
		s2[RBD_S2_INACTIVE] = 1'b0;
		s2[RBD_S2_SYNC] = sync_mode;
		s2[RBD_S2_FREEZE] = freeze_mode;
		s2[RBD_S2_ONE] = 1'b1;
		s2[RBD_S2_ZERO] = 1'b0;
		s2[RBD_S2_WAIT_PRM] = wait_prm;
	end

	logic [RBD_REPORT_BYTES*8-1:0] report_now;
	rbd_report u_rep (
		.s1(s1),
		.s2(s2),
		.prm_done(prm_done),
		.master_addr(master_addr),
		.ident(IDENT),
		.remote_req(remote_port_req),
		.slots(slots),
		.report(report_now)
	);

	// whole report latched in one edge so flags and bitmaps agree
	logic snap;
	assign snap = slave_diag_read_instruction | snap_req_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			diag_report <= '0;
		end else if (snap) begin
			diag_report <= report_now;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			diag_valid <= 1'b0;
		end else begin
			diag_valid <= snap;
		end
	end

	// read data registered at the address phase so it stands in the data phase
	logic [31:0] rd_d;
	logic [3:0] rpt_idx;
	logic [RBD_REPORT_BYTES*8+7:0] rpt_pad;
	assign rpt_pad = {diag_report, 8'h00};
	assign rpt_idx = 4'((haddr[7:0] - RBD_OFF_REPORT0) >> 2);
	always_comb begin
		rd_d = 32'h0000_0000;
		if (haddr[7:0] == RBD_OFF_CTRL) begin
			rd_d[RBD_CTRL_LENIENT] = lenient_q;
		end else if (haddr[7:0] == RBD_OFF_STATUS) begin
			rd_d[2:0] = disp_code;
			rd_d[RBD_ST_POINT] = disp_point;
			rd_d[RBD_ST_OFFLINE] = base_offline;
			rd_d[RBD_ST_OUT_HOLD] = outputs_hold;
			rd_d[RBD_ST_OUT_OFF] = outputs_off;
			rd_d[RBD_ST_IN_OFF] = inputs_off;
			rd_d[RBD_ST_JUMPER] = jmp_hold_q;
		end else if (haddr[7:0] == RBD_OFF_SLOTS) begin
			rd_d = {slots.fault, slots.mismatch};
		end else if (haddr[7:0] >= RBD_OFF_REPORT0 && haddr[7:0] <= RBD_OFF_REPORT3 && haddr[1:0] == 2'b00) begin
			// bytes 1..4 in word 0, byte 1 in the top lane; last word has a zero low lane
			rd_d = rpt_pad[(3 - rpt_idx) * 32 +: 32];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (aph_take && !hwrite) begin
			hrdata <= rd_d;
		end
	end

	// checks
	sequence s_diag_req;
		slave_diag_read_instruction && !rst;
	endsequence
	sequence s_report_out;
		diag_valid;
	endsequence

	a_snapshot_bitmap: assert property (@(posedge ref_clk) disable iff (rst)
		s_diag_req |=> s_report_out ##0
		(diag_report[32 +: 8] == $past(slots.mismatch[7:0]) && diag_report[0 +: 8] == $past(slots.fault[15:8])))
		else $error("report bitmaps differ from request-time slots");
	a_fixed_headers: assert property (@(posedge ref_clk) disable iff (rst)
		s_report_out |-> diag_report[64 +: 8] == RBD_EXT_DEV_HDR && diag_report[16 +: 8] == RBD_EXT_ID_HDR)
		else $error("extended headers wrong");
	a_status_fixed: assert property (@(posedge ref_clk) disable iff (rst)
		s_report_out |-> (diag_report[104 +: 8] & 8'h86) == 8'h04 && diag_report[96 +: 8] == 8'h00
		&& !diag_report[112 + RBD_S1_INVALID])
		else $error("fixed status bits wrong");
	a_master_addr: assert property (@(posedge ref_clk) disable iff (rst)
		s_diag_req ##0 !prm_done |=> diag_report[88 +: 8] == RBD_NO_MASTER_ADDR)
		else $error("unparameterized address not 255");
	a_ident_order: assert property (@(posedge ref_clk) disable iff (rst)
		s_report_out |-> diag_report[72 +: 16] == IDENT)
		else $error("identity bytes wrong");
	a_strict_remove: assert property (@(posedge ref_clk) disable iff (rst)
		!lenient_q && any_removed && !any_wrong && !diag_fail && !link_down
		|=> disp_code == RBD_DISP_2 && base_offline && io_update_en == '0)
		else $error("strict removal not taken offline with code 2");
	a_strict_wrong: assert property (@(posedge ref_clk) disable iff (rst)
		!lenient_q && any_wrong && !diag_fail && !link_down |=> disp_code == RBD_DISP_LA && base_offline)
		else $error("strict wrong type not shown as a");
	a_added_ignored: assert property (@(posedge ref_clk) disable iff (rst)
		any_added && !any_removed && !any_wrong && !diag_fail && !link_down
		|=> disp_code == RBD_DISP_0 && !base_offline && io_update_en == $past(cfg_present))
		else $error("added module disturbed operation");
	a_lenient_skip: assert property (@(posedge ref_clk) disable iff (rst)
		lenient_q && !diag_fail && !link_down |=> disp_point && !base_offline
		&& (io_update_en & $past(slots.mismatch)) == '0)
		else $error("lenient mode did not skip bad slots");
	a_bus_stop: assert property (@(posedge ref_clk) disable iff (rst)
		bus_stop && !diag_fail |=> disp_code == RBD_DISP_3 && inputs_off)
		else $error("bus stop not shown as 3 with inputs off");
	a_jumper_out: assert property (@(posedge ref_clk) disable iff (rst)
		(offline_d || link_down) |=> (outputs_hold == $past(jmp_hold_q)) && (outputs_off != outputs_hold))
		else $error("outputs not following jumper");
	a_fail_code: assert property (@(posedge ref_clk) disable iff (rst)
		diag_fail |=> disp_code == ($past(diag_fail_e) ? RBD_DISP_E : RBD_DISP_UA))
		else $error("failure code not A or E");
	a_strict_default: assert property (@(posedge ref_clk)
		$fell(rst) |-> !lenient_q)
		else $error("matching not strict after reset");
endmodule

// file: verification/rbd_master_model.sv
`timescale 1ns/1ps
module rbd_master_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic go,
	input wire logic base_offline,
	input wire logic comm_lost,
	output logic slave_diag_read_instruction,
	output logic [15:0] no_resp_cnt_q,
	output logic fault_bit_q
);
	logic lost_q;
	// the diagnostic read copies go one edge later, so it stays high for as many cycles as the bench holds go
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slave_diag_read_instruction <= 1'b0;
		end else begin
			slave_diag_read_instruction <= go;
		end
	end
	// one count per cycle that sees a new loss or the base offline, on a strict-mode mismatch or an internal failure
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			no_resp_cnt_q <= 16'h0000;
			lost_q <= 1'b0;
		end else begin
			lost_q <= comm_lost;
			if (base_offline || (comm_lost && !lost_q)) begin
				no_resp_cnt_q <= no_resp_cnt_q + 16'h0001;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fault_bit_q <= 1'b0;
		end else begin
			fault_bit_q <= comm_lost | base_offline;
		end
	end
endmodule

// file: verification/remote_base_diag_mismatch_tb_top.sv
`timescale 1ns/1ps
module remote_base_diag_mismatch_tb_top;
	import rbd_pkg::*;
	// flags: lenient, bus stop, link lost, internal fail, fail code E
	typedef struct packed {logic [15:0] cp, ip, wr, fl; logic [4:0] f; rbd_disp_t d; logic off;} rbd_row_t;
	localparam rbd_row_t ROWS [12] = '{
		'{16'h00FF, 16'h00FF, 16'h0000, 16'h0000, 5'h00, RBD_DISP_0, 1'b0},
		'{16'h00FF, 16'h00FE, 16'h0000, 16'h0000, 5'h00, RBD_DISP_2, 1'b1},
		'{16'h00FF, 16'h80FF, 16'h0000, 16'h0000, 5'h00, RBD_DISP_0, 1'b0},
		'{16'hFFFF, 16'hFFFD, 16'h0100, 16'h0000, 5'h00, RBD_DISP_LA, 1'b1},
		'{16'h00FF, 16'h00FF, 16'h0000, 16'h0004, 5'h00, RBD_DISP_0, 1'b0},
		'{16'hFFFF, 16'h7FFF, 16'h0000, 16'h0000, 5'h10, RBD_DISP_2, 1'b0},
		'{16'hFFFF, 16'hFFFF, 16'h0001, 16'h0000, 5'h10, RBD_DISP_2, 1'b0},
		'{16'h00FF, 16'h01FF, 16'h0000, 16'h0000, 5'h10, RBD_DISP_0, 1'b0},
		'{16'h00FF, 16'h00FF, 16'h0000, 16'h0000, 5'h08, RBD_DISP_3, 1'b0},
		'{16'h00FF, 16'h00FF, 16'h0000, 16'h0000, 5'h04, RBD_DISP_3, 1'b0},
		'{16'h00FF, 16'h00FF, 16'h0000, 16'h0000, 5'h02, RBD_DISP_UA, 1'b1},
		'{16'h00FF, 16'h00FE, 16'h0000, 16'h0000, 5'h0B, RBD_DISP_E, 1'b1}};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic go = 1'b0;
	logic jmp = 1'b0;
	logic pdone = 1'b0;
	logic len = 1'b0;
	logic stop = 1'b0;
	logic lost = 1'b0;
	logic df = 1'b0;
	logic dfe = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] cp = 16'h0;
	logic [15:0] ip = 16'h0;
	logic [15:0] wr = 16'h0;
	logic [15:0] fl = 16'h0;
	logic [9:0] fv = 10'h0;
	logic [7:0] maddr = 8'h0;
	logic [127:0] ct;
	logic [127:0] it;
	logic hreadyout, hresp, diag_valid, disp_point, base_offline, outputs_hold, outputs_off, inputs_off, instr;
	logic [31:0] hrdata;
	logic [119:0] diag_report;
	logic [15:0] io_update_en;
	rbd_disp_t disp_code;
	int miscompares = 0;
	int n_tests = 0;

	always #50 ref_clk = ~ref_clk;

	// installed types equal the configured ones except where a slot is marked wrong
	always_comb begin
		for (int g = 0; g < 16; g++) begin
			ct[g*8+:8] = 8'(g + 1);
			it[g*8+:8] = 8'(g + 1) ^ {wr[g], 7'h00};
		end
	end

	rbd_diag i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.cfg_present(cp), .cfg_type(ct), .inst_present(ip), .inst_type(it), .inst_failed(fl),
		.prm_other_master(fv[9]), .prm_error(fv[8]), .unsupported_fn(fv[7]), .cfg_error(fv[6]),
		.not_ready(fv[5]), .no_response(fv[4]), .sync_mode(fv[3]), .freeze_mode(fv[2]), .wait_prm(fv[1]),
		.prm_done(pdone), .master_addr(maddr), .remote_port_req(fv[0]), .bus_stop(stop), .comm_lost(lost),
		.diag_fail(df), .diag_fail_e(dfe), .output_off_hold_jumper(jmp), .slave_diag_read_instruction(instr),
		.diag_valid(diag_valid), .diag_report(diag_report), .disp_code(disp_code), .disp_point(disp_point),
		.base_offline(base_offline), .outputs_hold(outputs_hold), .outputs_off(outputs_off),
		.inputs_off(inputs_off), .io_update_en(io_update_en));

	rbd_master_model i_master (.ref_clk(ref_clk), .rst(rst), .go(go), .base_offline(base_offline),
		.comm_lost(lost), .slave_diag_read_instruction(instr), .no_resp_cnt_q(), .fault_bit_q());

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [119:0] seen, input logic [119:0] exp, input string m);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s: seen %h expected %h", $time, m, seen, exp);
		end
	endtask

	task automatic give_up();
		miscompares++;
		$display("MISMATCH t=%0t wait limit used up", $time);
		end_of_test();
	endtask

	// single word transfer; hready is sampled, never assumed
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge ref_clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		r = hrdata;
		chk(hresp, 1'b0, "response");
		if (k >= 50) begin
			give_up();
		end
	endtask

	task automatic wait_valid();
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (diag_valid !== 1'b1 && k < 20);
		if (k >= 20) begin
			give_up();
		end
	endtask

	task automatic req();
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		wait_valid();
	endtask

	function automatic logic [119:0] exp_rep();
		logic [15:0] m;
		logic [15:0] f;
		m = cp & (~ip | wr);
		f = m | (cp & fl);
		return {fv[9:8], 1'b0, fv[7], 1'b1, fv[6] | (~len & (|m)), fv[5:4], 2'b00, fv[3:2], 3'b010, fv[1], 8'h00,
			pdone ? maddr : RBD_NO_MASTER_ADDR, RBD_IDENT_DEFAULT, RBD_EXT_DEV_HDR, 7'h00, fv[0], 16'h0000,
			m[7:0], m[15:8], RBD_EXT_ID_HDR, f[7:0], f[15:8]};
	endfunction

	initial begin
		rbd_row_t r;
		logic [15:0] mm;
		logic [15:0] ft;
		logic lk;
		logic [31:0] rd;
		logic [119:0] e1;
		logic [127:0] ew;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			r = ROWS[i];
			cp <= r.cp;
			ip <= r.ip;
			wr <= r.wr;
			fl <= r.fl;
			{len, stop, lost, df, dfe} <= r.f;
			jmp <= i[0];
			ahb(1'b1, RBD_OFF_CTRL, {31'h0, r.f[4]}, rd);
			repeat (2) @(posedge ref_clk);
			req();
			mm = cp & (~ip | wr);
			ft = mm | (cp & fl);
			lk = r.off | r.f[3] | r.f[2];
			chk(diag_report, exp_rep(), "report");
			chk(disp_code, r.d, "display");
			chk(disp_point, r.f[4], "point");
			chk(base_offline, r.off, "offline");
			chk({outputs_hold, outputs_off}, lk ? {jmp, ~jmp} : 2'b00, "outputs");
			chk(inputs_off, lk, "inputs");
			chk(io_update_en, lk ? 16'h0000 : cp & ~mm, "io update");
			ahb(1'b0, RBD_OFF_SLOTS, 32'h0, rd);
			chk(rd, {ft, mm}, "slot register");
			ahb(1'b0, RBD_OFF_STATUS, 32'h0, rd);
			chk(rd[9:0], {jmp, lk, ~jmp & lk, jmp & lk, r.off, r.f[4], 1'b0, 3'(r.d)}, "status");
			$display("row %0d done", i);
		end
		for (int b = 0; b < 10; b++) begin
			fv <= 10'h001 << b;
			pdone <= b[0];
			maddr <= 8'(b * 37);
			@(posedge ref_clk);
			req();
			chk(diag_report, exp_rep(), "flag report");
		end
		$display("flag test done");
		// two requests back to back, with the pending flag changing between them
		fv <= 10'h000;
		@(posedge ref_clk);
		e1 = exp_rep();
		go <= 1'b1;
		repeat (2) @(posedge ref_clk);
		fv <= 10'h001;
		go <= 1'b0;
		@(posedge ref_clk);
		chk({diag_valid, diag_report}, {1'b1, e1}, "first report");
		@(posedge ref_clk);
		chk({diag_valid, diag_report}, {1'b1, e1 | (120'h1 << 56)}, "second report");
		ahb(1'b1, RBD_OFF_CTRL, 32'h0000_0002, rd);
		wait_valid();
		chk(diag_report, exp_rep(), "snapshot report");
		// report words read back over the bus, byte 1 in the top lane, last low lane zero
		ew = {exp_rep(), 8'h00};
		for (int w = 0; w < 4; w++) begin
			ahb(1'b0, RBD_OFF_REPORT0 + 8'(w * 4), 32'h0, rd);
			chk(rd, ew[(3 - w) * 32 +: 32], "report word");
		end
		ahb(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
		ahb(1'b0, 8'h40, 32'h0, rd);
		chk(rd, 32'h0, "unmapped read");
		ahb(1'b0, RBD_OFF_CTRL, 32'h0, rd);
		chk(rd, 32'h0, "control after unmapped write");
		$display("back to back and register test done");
		ahb(1'b1, RBD_OFF_CTRL, 32'h0000_0001, rd);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(diag_report, 120'h0, "reset report");
		chk({disp_code, disp_point, base_offline, outputs_hold, outputs_off, inputs_off, io_update_en},
			{8'h03, 16'h0000}, "reset outputs");
		rst <= 1'b0;
		ahb(1'b0, RBD_OFF_CTRL, 32'h0, rd);
		chk(rd, 32'h0, "strict after reset");
		$display("reset test done");
		end_of_test();
	end
endmodule
